// ===== smrw_defines.svh
// Purpose: Shared constants for the serial memory read/write front end.
// Assumes: Included by bare name; definitions only.
// Notes: Opcode values outside the write group are defaults that may be retuned.
`ifndef SMRW_DEFINES_SVH
`define SMRW_DEFINES_SVH

// Memory read opcodes.
`define SMRW_OP_READ 8'h03
`define SMRW_OP_FAST 8'h0b
`define SMRW_DUAL_OUTPUT_READ_CMD 8'h3b
`define SMRW_FOUR_OUTPUT_READ_CMD 8'h6b
`define SMRW_DUAL_ADDR_DATA_READ_CMD 8'hbb
`define SMRW_FOUR_ADDR_DATA_READ_CMD 8'heb

// Memory write opcodes and the latch-setting opcode.
`define SMRW_OP_WRITE 8'h02
`define SMRW_OP_DIW 8'ha2
`define SMRW_OP_QIW 8'h32
`define SMRW_OP_DIOW 8'ha1
`define SMRW_OP_QIOW 8'hd2
`define SMRW_WRITE_ENABLE_CMD 8'h06

// Phase lengths in bits and address limits.
`define SMRW_ADDR_BITS 5'h18
`define SMRW_BYTE_BITS 5'h08
`define SMRW_ADDR_LAST 17'h1ffff
`define SMRW_ADDR_ZERO 17'h00000

// Reset values: latch clear, synchroniser bits {write enable, write, store busy, select}.
`define SMRW_RST_LATCH 1'h0
`define SMRW_SYNC_RST 4'h3

`endif

// ===== smrw_pkg.sv
// Purpose: Types for the serial memory read/write front end.
// Assumes: Constants live in smrw_defines.svh.
// Notes: Lane widths are coded 0 = one line, 1 = two, 2 = four.
package smrw_pkg;

	// Link-side sequencer states.
	typedef enum logic [2:0] {
		st_cmd = 3'b000,
		st_addr = 3'b001,
		st_mode = 3'b010,
		st_dummy = 3'b011,
		st_rd = 3'b100,
		st_wr = 3'b101,
		st_ign = 3'b110
	} smrw_state_t;

	// Decoded command attributes.
	typedef struct packed {
		logic ok;
		logic rd;
		logic write_enable_cmd;
		logic mode;
		logic dummy;
		logic [1:0] aw;
		logic [1:0] dw;
	} smrw_cmd_t;

	// Configuration word frozen for the length of a frame.
	typedef struct packed {
		logic busy;
		logic latch;
		logic quad;
		logic dual;
		logic four;
		logic [7:0] prot;
	} smrw_cfg_t;

	// One write byte handed to the system domain.
	typedef struct packed {
		logic [16:0] addr;
		logic [7:0] data;
	} smrw_wr_t;

endpackage

// ===== smrw_serial_mem_access.sv
// Purpose: Read and write command front end of a serial SRAM link.
// Assumes: Array has an asynchronous read port and a clk_sys write port.
// Notes: Link logic runs on sck and, except the toggles and the held write byte, is held in reset while cs_n is high.
`timescale 1ns/100ps
`include "smrw_defines.svh"

// What this block does
// RULE1: No reads serviced during save or restore.
// RULE2: Opcode then three address bytes, 17-bit address.
// RULE3: Bit 16 from first byte bit 0.
// RULE4: Data launched on falling edges, MSB first.
// RULE5: Read address increments and wraps to zero.
// RULE6: Raising chip select stops data drive.
// RULE7: Host keeps plain read at 40 MHz.
// RULE8: Plain read in dual/quad adds dummy period.
// RULE9: Single line: in on SI, out SO.
// RULE10: Dual link uses lines 1 and 0.
// RULE11: Quad link uses lines 3 to 0.
// RULE12: Quad commands need quad width bit set.
// RULE13: Fast reads carry one mode byte.
// RULE14: Host clocks fast and writes at 108 MHz.
// RULE15: Dual output read: serial header, two-bit data.
// RULE16: Quad output read: serial header, four-bit data.
// RULE17: Dual address/data read: two-bit address and data.
// RULE18: Quad address/data read: four-bit address and data.
// RULE19: Writes ignored unless write latch flag set.
// RULE20: Burst writes increment address and wrap.
// RULE21: Array writes leave write latch flag unchanged.
// RULE22: Protected blocks skip data, address still advances.
// RULE23: Write enable sets latch when frame ends.
// RULE24: Busy rejects every new command here.
// RULE25: Quad width bit turns spare pins into lanes.
// RULE26: Inputs sampled on rising serial clock edges.
module smrw_serial_mem_access (
	input logic clk_sys,
	input logic rst_n,
	input logic sck,
	input logic cs_n,
	input logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe,
	input logic work_pending_flag,
	input logic hardware_store_busy_pin_n,
	input logic config_width_bit,
	input logic dual_link_mode,
	input logic four_line_link_mode,
	input logic [7:0] protect_blocks,
	input logic write_latch_clear,
	output logic [16:0] rd_addr,
	input logic [7:0] rd_data,
	output logic mem_wr_en,
	output logic [16:0] mem_wr_addr,
	output logic [7:0] mem_wr_data,
	output logic write_latch_flag
);

	localparam logic [3:0] sync_rst = `SMRW_SYNC_RST;

	// Link domain state.
	smrw_pkg::smrw_state_t st_reg, st_next;
	smrw_pkg::smrw_cmd_t info_reg, cmd;
	smrw_pkg::smrw_wr_t wr_hold_reg;
	logic [4:0] cnt_reg, cnt_next, cnt_inc, step, phase_len;
	logic [7:0] sh_reg, sh_next, tx_byte_reg, tx_src, tx_shift;
	logic [16:0] addr_reg, addr_next, addr_shift;
	logic [3:0] io_out_reg, io_oe_reg, lanes_out, lanes_oe;
	logic [1:0] hw, lw;
	logic frame_rst_n, done, data_st, in_rd, wr_fire, wen_fire;
	logic wr_tgl_reg, wen_tgl_reg;

	// System domain state.
	smrw_pkg::smrw_cfg_t cfg_reg, cfg_next;
	logic [3:0] meta_reg, sync_reg, sync_in;
	logic [1:0] evt_del_reg;
	logic mem_wr_en_reg, pend_reg, pend_next;
	logic write_latch_flag_reg, latch_next, busy_now;
	logic wr_evt, wen_evt, idle;
	logic [16:0] mem_wr_addr_reg;
	logic [7:0] mem_wr_data_reg;

	// Decode an opcode against the link width and frozen configuration.
	function automatic smrw_pkg::smrw_cmd_t smrw_decode(
		input logic [7:0] op,
		input logic [1:0] w,
		input smrw_pkg::smrw_cfg_t c
	);
		smrw_pkg::smrw_cmd_t r;
		logic spi;
		r = '0;
		spi = (w == 2'h0);
		r.ok = 1'h1;
		r.aw = w;
		r.dw = w;
		case (op)
			`SMRW_OP_READ: begin
				r.rd = 1'h1;
				r.dummy = !spi; // RULE8
			end
			`SMRW_OP_FAST: begin
				r.rd = 1'h1;
				r.mode = 1'h1; // RULE13
			end
			`SMRW_DUAL_OUTPUT_READ_CMD: begin
				r.rd = 1'h1;
				r.mode = 1'h1;
				r.dw = 2'h1; // RULE15
				r.ok = spi;
			end
			`SMRW_FOUR_OUTPUT_READ_CMD: begin
				r.rd = 1'h1;
				r.mode = 1'h1;
				r.dw = 2'h2; // RULE16
				r.ok = spi && c.quad; // RULE12
			end
			`SMRW_DUAL_ADDR_DATA_READ_CMD: begin
				r.rd = 1'h1;
				r.mode = 1'h1;
				r.aw = 2'h1; // RULE17
				r.dw = 2'h1;
				r.ok = spi;
			end
			`SMRW_FOUR_ADDR_DATA_READ_CMD: begin
				r.rd = 1'h1;
				r.mode = 1'h1;
				r.aw = 2'h2; // RULE18
				r.dw = 2'h2;
				r.ok = spi && c.quad; // RULE12
			end
			`SMRW_OP_WRITE: r.ok = 1'h1;
			`SMRW_OP_DIW: begin
				r.dw = 2'h1;
				r.ok = spi;
			end
			`SMRW_OP_QIW: begin
				r.dw = 2'h2;
				r.ok = spi && c.quad;
			end
			`SMRW_OP_DIOW: begin
				r.aw = 2'h1;
				r.dw = 2'h1;
				r.ok = spi;
			end
			`SMRW_OP_QIOW: begin
				r.aw = 2'h2;
				r.dw = 2'h2;
				r.ok = spi && c.quad;
			end
			`SMRW_WRITE_ENABLE_CMD: r.write_enable_cmd = 1'h1;
			default: r.ok = 1'h0;
		endcase
		// Quad link framing is only legal once the quad width bit is set.
		if (w == 2'h2 && !c.quad)
			r.ok = 1'h0; // RULE12 RULE25
		if (!r.rd && !r.write_enable_cmd && !c.latch)
			r.ok = 1'h0; // RULE19
		if (c.busy)
			r.ok = 1'h0; // RULE24 RULE1
		return r;
	endfunction

	// The link logic lives only inside a frame; cs_n high clears it at once.
	assign frame_rst_n = rst_n & ~cs_n;

	// Lane width of the current phase and the bits it takes per rising edge.
	assign hw = cfg_reg.four ? 2'h2 : (cfg_reg.dual ? 2'h1 : 2'h0);
	assign lw = (st_reg == smrw_pkg::st_cmd) ? hw :
		(st_reg == smrw_pkg::st_rd || st_reg == smrw_pkg::st_wr) ? info_reg.dw : info_reg.aw;
	assign step = 5'h01 << lw;
	assign cnt_inc = cnt_reg + step;
	assign phase_len = (st_reg == smrw_pkg::st_addr) ? `SMRW_ADDR_BITS : `SMRW_BYTE_BITS;
	assign done = (cnt_inc == phase_len);
	assign data_st = (st_reg == smrw_pkg::st_rd) || (st_reg == smrw_pkg::st_wr);
	assign in_rd = (st_reg == smrw_pkg::st_rd);

	// Input lanes: SI alone, lines 1..0 or lines 3..0, first bit highest.
	assign sh_next = (lw == 2'h0) ? {sh_reg[6:0], io_in[0]} :
		(lw == 2'h1) ? {sh_reg[5:0], io_in[1:0]} : {sh_reg[3:0], io_in}; // RULE9 RULE10 RULE11
	// Only the last 17 address bits survive, so byte one keeps just bit 0.
	assign addr_shift = (lw == 2'h0) ? {addr_reg[15:0], io_in[0]} :
		(lw == 2'h1) ? {addr_reg[14:0], io_in[1:0]} : {addr_reg[12:0], io_in}; // RULE3
	assign cmd = smrw_decode(sh_next, hw, cfg_reg);

	// Address: shifted in, then stepped after each data byte, wrapping at the top.
	assign addr_next = (st_reg == smrw_pkg::st_addr) ? addr_shift :
		(data_st && done) ? addr_reg + 17'h00001 : addr_reg; // RULE5 RULE20

	// A byte reaches the array only outside protected blocks.
	assign wr_fire = (st_reg == smrw_pkg::st_wr) && done &&
		!cfg_reg.prot[addr_reg[16:14]]; // RULE22
	assign wen_fire = (st_reg == smrw_pkg::st_cmd) && done && cmd.ok && cmd.write_enable_cmd;

	// Phase sequencer.
	always_comb begin
		st_next = st_reg;
		cnt_next = done ? 5'h00 : cnt_inc;
		case (st_reg)
			smrw_pkg::st_cmd: begin
				if (done)
					st_next = (cmd.ok && !cmd.write_enable_cmd) ? smrw_pkg::st_addr :
						smrw_pkg::st_ign; // RULE24
			end
			smrw_pkg::st_addr: begin
				if (done) begin // RULE2
					if (info_reg.mode)
						st_next = smrw_pkg::st_mode; // RULE13
					else if (info_reg.dummy)
						st_next = smrw_pkg::st_dummy; // RULE8
					else
						st_next = info_reg.rd ? smrw_pkg::st_rd : smrw_pkg::st_wr;
				end
			end
			smrw_pkg::st_mode: begin
				if (done)
					st_next = smrw_pkg::st_rd;
			end
			smrw_pkg::st_dummy: begin
				st_next = smrw_pkg::st_rd;
				cnt_next = 5'h00;
			end
			smrw_pkg::st_rd: st_next = smrw_pkg::st_rd; // RULE4
			smrw_pkg::st_wr: st_next = smrw_pkg::st_wr; // RULE20
			smrw_pkg::st_ign: st_next = smrw_pkg::st_ign;
			default: st_next = smrw_pkg::st_ign;
		endcase
	end

	// Rising-edge capture of opcode, address, mode and write data.
	always_ff @(posedge sck or negedge frame_rst_n) begin // RULE26
		if (!frame_rst_n) begin
			st_reg <= smrw_pkg::st_cmd;
			cnt_reg <= 5'h00;
			sh_reg <= 8'h00;
			addr_reg <= `SMRW_ADDR_ZERO;
			info_reg <= '0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			addr_reg <= addr_next;
			if (st_reg == smrw_pkg::st_cmd && done)
				info_reg <= cmd;
		end
	end

	// Toggles and the held byte must outlive the frame, so only rst_n clears them.
	always_ff @(posedge sck or negedge rst_n) begin
		if (!rst_n) begin
			wr_tgl_reg <= 1'h0;
			wen_tgl_reg <= 1'h0;
			wr_hold_reg <= '0;
		end else begin
			if (wr_fire) begin
				wr_tgl_reg <= ~wr_tgl_reg;
				wr_hold_reg <= {addr_reg, sh_next};
			end
			if (wen_fire)
				wen_tgl_reg <= ~wen_tgl_reg; // RULE23
		end
	end

	// Output lanes: the first slice of a byte comes straight from the array.
	assign tx_src = (cnt_reg == 5'h00) ? rd_data : tx_byte_reg;
	assign tx_shift = tx_src << cnt_reg[2:0];
	assign lanes_out = !in_rd ? 4'h0 :
		(info_reg.dw == 2'h0) ? {2'h0, tx_shift[7], 1'h0} :
		(info_reg.dw == 2'h1) ? {2'h0, tx_shift[7:6]} : tx_shift[7:4]; // RULE9 RULE10 RULE11
	assign lanes_oe = !in_rd ? 4'h0 :
		(info_reg.dw == 2'h0) ? 4'h2 :
		(info_reg.dw == 2'h1) ? 4'h3 : 4'hf; // RULE15 RULE16 RULE25

	// Falling-edge launch; cs_n high drops every enable without waiting for sck.
	always_ff @(negedge sck or negedge frame_rst_n) begin // RULE4 RULE6
		if (!frame_rst_n) begin
			io_out_reg <= 4'h0;
			io_oe_reg <= 4'h0;
			tx_byte_reg <= 8'h00;
		end else begin
			io_out_reg <= lanes_out;
			io_oe_reg <= lanes_oe;
			tx_byte_reg <= tx_src;
		end
	end

	// Two-flop synchronisers into clk_sys for cs_n, store busy and both toggles.
	assign sync_in = {wen_tgl_reg, wr_tgl_reg, hardware_store_busy_pin_n, cs_n};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					meta_reg[gi] <= sync_rst[gi];
					sync_reg[gi] <= sync_rst[gi];
				end else begin
					meta_reg[gi] <= sync_in[gi];
					sync_reg[gi] <= meta_reg[gi];
				end
			end
		end
	endgenerate

	// Event and latch decoding in the system domain.
	assign idle = sync_reg[0];
	assign wr_evt = sync_reg[2] ^ evt_del_reg[0];
	assign wen_evt = sync_reg[3] ^ evt_del_reg[1];
	assign busy_now = work_pending_flag | ~sync_reg[1]; // RULE1
	assign pend_next = wen_evt | (pend_reg & ~idle);
	// Setting wins over a clear in the same cycle; array writes never clear it.
	assign latch_next = (pend_reg & idle) |
		(write_latch_flag_reg & ~write_latch_clear); // RULE23 RULE21
	assign cfg_next = {busy_now, write_latch_flag_reg, config_width_bit,
		dual_link_mode, four_line_link_mode, protect_blocks};

	// The configuration word only moves while the link is idle, so sck logic
	// can read it directly; it is frozen from a few clk_sys cycles after cs_n falls.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			evt_del_reg <= 2'h0;
			mem_wr_en_reg <= 1'h0;
			mem_wr_addr_reg <= `SMRW_ADDR_ZERO;
			mem_wr_data_reg <= 8'h00;
			pend_reg <= 1'h0;
			write_latch_flag_reg <= `SMRW_RST_LATCH;
			cfg_reg <= '0;
		end else begin
			evt_del_reg <= sync_reg[3:2];
			mem_wr_en_reg <= wr_evt;
			if (wr_evt) begin
				mem_wr_addr_reg <= wr_hold_reg.addr;
				mem_wr_data_reg <= wr_hold_reg.data;
			end
			pend_reg <= pend_next;
			write_latch_flag_reg <= latch_next;
			if (idle)
				cfg_reg <= cfg_next;
		end
	end

	assign io_out = io_out_reg;
	assign io_oe = io_oe_reg;
	assign rd_addr = addr_reg;
	assign mem_wr_en = mem_wr_en_reg;
	assign mem_wr_addr = mem_wr_addr_reg;
	assign mem_wr_data = mem_wr_data_reg;
	assign write_latch_flag = write_latch_flag_reg;

	// Checks on the link side.
	property p_busy_reject;
		@(posedge sck) disable iff (!frame_rst_n)
		(st_reg == smrw_pkg::st_cmd && done && cfg_reg.busy) |=> (st_reg == smrw_pkg::st_ign);
	endproperty
	a_busy_reject: assert property (p_busy_reject) // RULE24
		else $error("Command accepted while busy.");

	property p_no_latch;
		@(posedge sck) disable iff (!frame_rst_n)
		(st_reg == smrw_pkg::st_cmd && done && !cfg_reg.latch && !cmd.rd &&
		!cmd.write_enable_cmd)
		|=> (st_reg == smrw_pkg::st_ign);
	endproperty
	a_no_latch: assert property (p_no_latch) // RULE19
		else $error("Write accepted without write latch.");

	property p_addr_len;
		@(posedge sck) disable iff (!frame_rst_n)
		(st_reg == smrw_pkg::st_addr && cnt_inc < `SMRW_ADDR_BITS) |=> (st_reg == smrw_pkg::st_addr);
	endproperty
	a_addr_len: assert property (p_addr_len) // RULE2
		else $error("Address phase left early.");

	property p_wrap;
		@(posedge sck) disable iff (!frame_rst_n)
		(data_st && done && addr_reg == `SMRW_ADDR_LAST) |=> (addr_reg == `SMRW_ADDR_ZERO);
	endproperty
	a_wrap: assert property (p_wrap) // RULE5
		else $error("Address did not wrap to zero.");

	property p_prot_skip;
		@(posedge sck) disable iff (!frame_rst_n)
		(st_reg == smrw_pkg::st_wr && done && cfg_reg.prot[addr_reg[16:14]])
		|=> $stable(wr_tgl_reg) ##1 (addr_reg != $past(addr_reg, 2));
	endproperty
	a_prot_skip: assert property (p_prot_skip) // RULE22
		else $error("Protected byte written or address held.");

	property p_oe_rd;
		@(posedge sck) disable iff (!frame_rst_n)
		(io_oe_reg != 4'h0) |-> (st_reg == smrw_pkg::st_rd);
	endproperty
	a_oe_rd: assert property (p_oe_rd) // RULE4
		else $error("Lanes driven outside data output.");

	property p_lane_single;
		@(posedge sck) disable iff (!frame_rst_n)
		(in_rd && info_reg.dw == 2'h0) |-> (io_oe_reg == 4'h2);
	endproperty
	a_lane_single: assert property (p_lane_single) // RULE9
		else $error("Single data not on line 1.");

	property p_lane_dual;
		@(posedge sck) disable iff (!frame_rst_n)
		(in_rd && info_reg.dw == 2'h1) |-> (io_oe_reg == 4'h3);
	endproperty
	a_lane_dual: assert property (p_lane_dual) // RULE10
		else $error("Dual data not on lines 1 and 0.");

	property p_lane_quad;
		@(posedge sck) disable iff (!frame_rst_n)
		(in_rd && info_reg.dw == 2'h2) |-> (io_oe_reg == 4'hf);
	endproperty
	a_lane_quad: assert property (p_lane_quad) // RULE11
		else $error("Quad data not on all four lines.");

	// Checks on the system side.
	property p_cs_quiet;
		@(posedge clk_sys) disable iff (!rst_n)
		(cs_n && idle) |-> (io_oe_reg == 4'h0);
	endproperty
	a_cs_quiet: assert property (p_cs_quiet) // RULE6
		else $error("Lanes driven with chip select high.");

	property p_latch_set;
		@(posedge clk_sys) disable iff (!rst_n)
		(pend_reg && idle) |=> write_latch_flag_reg [*2];
	endproperty
	a_latch_set: assert property (p_latch_set) // RULE23
		else $error("Write enable did not set the latch.");

	property p_latch_keep;
		@(posedge clk_sys) disable iff (!rst_n)
		$fell(write_latch_flag_reg) |-> $past(write_latch_clear);
	endproperty
	a_latch_keep: assert property (p_latch_keep) // RULE21
		else $error("Write latch fell without a clear.");

	c_read_byte: cover property (@(posedge sck) disable iff (!frame_rst_n) in_rd && done);
	c_write_byte: cover property (@(posedge clk_sys) disable iff (!rst_n) mem_wr_en_reg);
	c_wrap: cover property (@(posedge sck) disable iff (!frame_rst_n)
		data_st && done && addr_reg == `SMRW_ADDR_LAST);
	c_reject: cover property (@(posedge sck) disable iff (!frame_rst_n)
		st_reg == smrw_pkg::st_cmd && done && cfg_reg.busy);

endmodule

// ===== smrw_host_model.sv
// Purpose: Serial host that frames commands for the memory front end.
// Assumes: Clock polarity and phase mode 0 with a 125 ns serial period.
// Notes: The serial clock stands low between frames; released lanes toggle every cycle.
`timescale 1ns/100ps
module smrw_host_model (
	output logic sck,
	output logic cs_n,
	output logic [3:0] io_in,
	input logic [3:0] io_out,
	input logic [3:0] io_oe
);
	logic [3:0] hv;
	logic drv;
	logic [3:0] seen_oe;

	// Lanes that the device drives win, so a read sees the device and not stale host bits.
	assign io_in = (io_oe & io_out) | (~io_oe & hv);

	// Idle state before the first frame.
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		hv = 4'h0;
		drv = 1'b0;
		seen_oe = 4'h0;
	end

	// One serial cycle; a released host flips its lanes so an old value never looks valid.
	task automatic cyc(output logic [3:0] s);
		if (!drv) hv = ~hv;
		#62.5 sck = 1'b1;
		s = io_in;
		seen_oe = seen_oe | io_oe;
		#62.5 sck = 1'b0;
	endtask

	// Selects the device well ahead of the first rising edge.
	task automatic start();
		cs_n = 1'b0;
		seen_oe = 4'h0;
		#50;
	endtask

	// Deselects and leaves the system side time to commit writes and reload its settings.
	task automatic stop();
		#62.5 cs_n = 1'b1;
		drv = 1'b0;
		#400;
	endtask

	// Sends n bits most significant first, w lanes per cycle; one lane means line 0.
	task automatic send(input logic [31:0] val, input int n, input int w);
		logic [3:0] s;
		drv = 1'b1;
		for (int i = n - w; i >= 0; i -= w) begin
			hv = 4'((val >> i) & ((32'h1 << w) - 32'h1));
			cyc(s);
		end
	endtask

	// Collects n bits sampled on rising edges; one lane reads line 1.
	task automatic recv(input int n, input int w, output logic [31:0] val);
		logic [3:0] s;
		drv = 1'b0;
		val = 32'h0;
		for (int i = 0; i < n; i += w) begin
			cyc(s);
			val = (val << w) | ((w == 1) ? {31'h0, s[1]} : {28'h0, s & 4'((32'h1 << w) - 32'h1)});
		end
	endtask
endmodule

// ===== smrw_serial_mem_access_tb_top.sv
// Purpose: Self-checking bench for the serial memory read/write front end.
// Assumes: The array is modelled as a fixed pattern of the read address.
// Notes: Write commits are logged from the array write strobe and compared once each group of write frames is done.
`timescale 1ns/100ps
`include "smrw_defines.svh"
module smrw_serial_mem_access_tb_top;
	logic clk_sys, rst_n, sck, cs_n, work_pending_flag, hardware_store_busy_pin_n;
	logic config_width_bit, dual_link_mode, four_line_link_mode, write_latch_clear;
	logic mem_wr_en, write_latch_flag;
	logic [3:0] io_in, io_out, io_oe;
	logic [7:0] protect_blocks, rd_data, mem_wr_data;
	logic [16:0] rd_addr, mem_wr_addr;
	logic [31:0] got;
	smrw_pkg::smrw_wr_t wq[$];
	int bad_count, checks;
	logic [7:0] ops [5] = '{`SMRW_OP_FAST, `SMRW_DUAL_OUTPUT_READ_CMD,
		`SMRW_FOUR_OUTPUT_READ_CMD, `SMRW_DUAL_ADDR_DATA_READ_CMD,
		`SMRW_FOUR_ADDR_DATA_READ_CMD};
	int aws [5] = '{1, 1, 1, 2, 4};
	int dws [5] = '{1, 2, 4, 2, 4};

	// Array contents are a pattern, so any address slip changes the data.
	function automatic logic [7:0] pat(input logic [16:0] a);
		return a[7:0] ^ a[15:8] ^ {7'h0, a[16]} ^ 8'h5a;
	endfunction

	function automatic logic [23:0] exp3(input logic [16:0] a);
		return {pat(a), pat(a + 17'h1), pat(a + 17'h2)};
	endfunction

	assign rd_data = pat(rd_addr);

	// System clock.
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Logs every committed array write.
	always @(posedge clk_sys) begin
		if (mem_wr_en === 1'b1) wq.push_back('{mem_wr_addr, mem_wr_data});
	end

	smrw_serial_mem_access u_smrw_serial_mem_access (.clk_sys(clk_sys), .rst_n(rst_n),
		.sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
		.work_pending_flag(work_pending_flag),
		.hardware_store_busy_pin_n(hardware_store_busy_pin_n),
		.config_width_bit(config_width_bit), .dual_link_mode(dual_link_mode),
		.four_line_link_mode(four_line_link_mode), .protect_blocks(protect_blocks),
		.write_latch_clear(write_latch_clear), .rd_addr(rd_addr), .rd_data(rd_data),
		.mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
		.write_latch_flag(write_latch_flag));

	smrw_host_model u_smrw_host_model (.sck(sck), .cs_n(cs_n), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe));

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Settings change only between frames, with time for the frozen copy to reload.
	task automatic set_cfg(input logic [1:0] busy, input logic quad, input logic dual,
		input logic four, input logic [7:0] prot);
		@(posedge clk_sys);
		work_pending_flag <= busy[0];
		hardware_store_busy_pin_n <= ~busy[1];
		config_width_bit <= quad;
		dual_link_mode <= dual;
		four_line_link_mode <= four;
		protect_blocks <= prot;
		repeat (5) @(posedge clk_sys);
	endtask

	// Read frame; the don't-care address bits are sent as ones.
	task automatic rd(input logic [7:0] op, input int cw, input int aw, input int mw,
		input int dw, input int dm, input logic [16:0] a, output logic [31:0] v);
		u_smrw_host_model.start();
		u_smrw_host_model.send({24'h0, op}, 8, cw);
		u_smrw_host_model.send({8'h0, 7'h7f, a}, 24, aw);
		if (mw > 0) u_smrw_host_model.send(32'h0, 8, mw);
		u_smrw_host_model.recv(24 + dm, dw, v);
		u_smrw_host_model.stop();
	endtask

	// Single-line opcode, then address and three data bytes at the given lane widths.
	task automatic wr(input logic [7:0] op, input int aw, input int dw, input logic [16:0] a,
		input logic [23:0] d);
		u_smrw_host_model.start();
		u_smrw_host_model.send({24'h0, op}, 8, 1);
		u_smrw_host_model.send({15'h0, a}, 24, aw);
		u_smrw_host_model.send({8'h0, d}, 24, dw);
		u_smrw_host_model.stop();
	endtask

	task automatic complete_run();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Main sequence: reset, reads in every width, refusals, then writes.
	initial begin
		rst_n = 1'b0;
		{work_pending_flag, config_width_bit, dual_link_mode, four_line_link_mode} = 4'h0;
		hardware_store_busy_pin_n = 1'b1;
		protect_blocks = 8'h00;
		write_latch_clear = 1'b0;
		bad_count = 0;
		checks = 0;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk({9'h0, io_oe, mem_wr_en, write_latch_flag, rd_addr}, 32'h0);
		rd(`SMRW_OP_READ, 1, 1, 0, 1, 0, 17'h1fffe, got);
		chk(got[23:0], exp3(17'h1fffe));
		chk(io_oe, 32'h0);
		set_cfg(2'b00, 1'b1, 1'b0, 1'b0, 8'h00);
		for (int k = 0; k < 5; k++) begin
			rd(ops[k], 1, aws[k], aws[k], dws[k], 0, 17'h0a5c3 + 17'(k), got);
			chk(got[23:0], exp3(17'h0a5c3 + 17'(k)));
		end
		for (int b = 1; b < 3; b++) begin
			set_cfg(2'(b), 1'b1, 1'b0, 1'b0, 8'h00);
			rd(`SMRW_OP_READ, 1, 1, 0, 1, 0, 17'h00040, got);
			chk(u_smrw_host_model.seen_oe, 32'h0);
		end
		set_cfg(2'b00, 1'b0, 1'b0, 1'b0, 8'h00);
		rd(`SMRW_FOUR_OUTPUT_READ_CMD, 1, 1, 1, 4, 0, 17'h00040, got);
		chk(u_smrw_host_model.seen_oe, 32'h0);
		set_cfg(2'b00, 1'b1, 1'b1, 1'b0, 8'h00);
		rd(`SMRW_OP_READ, 2, 2, 0, 2, 2, 17'h12345, got);
		chk(got[23:0], exp3(17'h12345));
		set_cfg(2'b00, 1'b1, 1'b0, 1'b1, 8'h00);
		rd(`SMRW_OP_READ, 4, 4, 0, 4, 4, 17'h0fffe, got);
		chk(got[23:0], exp3(17'h0fffe));
		rd(`SMRW_OP_FAST, 4, 4, 4, 4, 0, 17'h1fffe, got);
		chk(got[23:0], exp3(17'h1fffe));
		set_cfg(2'b00, 1'b1, 1'b0, 1'b0, 8'h80);
		wq.delete();
		wr(`SMRW_OP_WRITE, 1, 1, 17'h00100, 24'h112233);
		chk(wq.size(), 32'h0);
		wr(`SMRW_WRITE_ENABLE_CMD, 1, 1, 17'h0, 24'h0);
		chk(write_latch_flag, 32'h1);
		wr(`SMRW_OP_WRITE, 1, 1, 17'h1ffff, 24'hc1d2e3);
		chk(wq.size(), 32'h2);
		chk(wq[0], {7'h0, 17'h00000, 8'hd2});
		chk(wq[1], {7'h0, 17'h00001, 8'he3});
		chk(write_latch_flag, 32'h1);
		// Wide write commands: two-lane address and data, then four-lane data only.
		wq.delete();
		wr(`SMRW_OP_DIOW, 2, 2, 17'h0c0de, 24'ha55a3c);
		wr(`SMRW_OP_QIW, 1, 4, 17'h00777, 24'h0f1e2d);
		chk(wq.size(), 32'h6);
		chk(wq[0], {7'h0, 17'h0c0de, 8'ha5});
		chk(wq[2], {7'h0, 17'h0c0e0, 8'h3c});
		chk(wq[3], {7'h0, 17'h00777, 8'h0f});
		chk(wq[5], {7'h0, 17'h00779, 8'h2d});
		chk(write_latch_flag, 32'h1);
		@(posedge clk_sys);
		write_latch_clear <= 1'b1;
		@(posedge clk_sys);
		write_latch_clear <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk(write_latch_flag, 32'h0);
		complete_run();
	end

	// A hang counts as a failure and ends the run the usual way.
	initial begin
		#900000;
		bad_count++;
		complete_run();
	end
endmodule
